// ---- hdl/acdp_aux_control.sv ----
`timescale 1ns/100ps
`include "acdp_regs.svh"
module acdp_aux_control (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // Special function register access
    input  wire logic [7:0]    sfr_addr,
    input  wire logic          sfr_we,
    input  wire logic [7:0]    sfr_wdata,
    input  wire logic          sfr_re,
    output logic [7:0]         sfr_rdata,
    // Pointer instruction requests
    input  wire logic          ptr_inc,
    input  wire logic          ptr_load,
    input  wire logic [15:0]   ptr_load_data,
    input  wire logic [7:0]    ptr_offset,
    // Addresses for pointer users
    output logic [15:0]        data_pointer,
    output logic [15:0]        code_read_addr,
    output logic [15:0]        jump_target,
    output logic [15:0]        config_read_addr,
    // Chip reset request
    output logic               chip_reset,
    output logic [15:0]        restart_addr
);
    acdp_ptr_if bus ();

    logic [7:0]                aux_reg;
    logic [7:0]                aux_next;
    acdp_pkg::acdp_state_type  state_reg;
    acdp_pkg::acdp_state_type  state_next;
    logic [7:0]                rdata_reg;
    logic [7:0]                rdata_next;
    logic [15:0]               ptr_out_reg;
    logic [15:0]               code_reg;
    logic [15:0]               jump_reg;
    logic [15:0]               cfg_reg;
    logic                      soft_rst;
    logic                      aux_wr;

    // Per-register write strobes
    logic                      low_wr;
    logic                      high_wr;

    // Output stage next values
    logic [15:0]               ptr_out_next;
    logic [15:0]               code_next;
    logic [15:0]               jump_next;
    logic [15:0]               cfg_next;
    logic                      reset_out_reg;
    logic                      reset_out_next;
    logic [15:0]               restart_reg;
    logic [15:0]               restart_next;

    // Stored bit mask: bit 2 hard-wired zero
    function automatic logic [7:0] aux_mask(input logic [7:0] v);
        logic [7:0] m;
        m = v;
        m[`ACDP_ZERO_BIT] = 1'b0;
        return m;
    endfunction

    // Pointer plus unsigned offset
    function automatic logic [15:0] ptr_add(input logic [15:0] p, input logic [7:0] o);
        return p + {8'h00, o};
    endfunction

    // Address match for one register
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    // Read value for one address
    function automatic logic [7:0] read_mux(input logic [7:0]  a,
                                            input logic [7:0]  aux,
                                            input logic [15:0] ptr);
        logic [7:0] v;
        v = 8'h00; // Unmapped addresses read zero
        if (addr_hit(a, `ACDP_AUX_CTRL_ADDR)) begin
            v = aux_mask(aux);
        end else if (addr_hit(a, `ACDP_PTR_LOW_ADDR)) begin
            v = ptr[7:0];
        end else if (addr_hit(a, `ACDP_PTR_HIGH_ADDR)) begin
            v = ptr[15:8];
        end
        return v;
    endfunction

    // Write strobes; byte writes dropped during reset cycle
    assign aux_wr   = sfr_we && addr_hit(sfr_addr, `ACDP_AUX_CTRL_ADDR);
    assign low_wr   = sfr_we && addr_hit(sfr_addr, `ACDP_PTR_LOW_ADDR) && !soft_rst;
    assign high_wr  = sfr_we && addr_hit(sfr_addr, `ACDP_PTR_HIGH_ADDR) && !soft_rst;
    assign soft_rst = (state_reg == acdp_pkg::ACDP_ST_RESET);

    // Register write and software reset sequencing
    always_comb begin
        aux_next   = aux_reg;
        state_next = acdp_pkg::ACDP_ST_RUN;
        if (soft_rst) begin
            aux_next = `ACDP_AUX_RESET;
        end else if (aux_wr) begin
            aux_next = aux_mask(sfr_wdata);
            if (sfr_wdata[`ACDP_SOFT_RST_BIT]) begin
                state_next = acdp_pkg::ACDP_ST_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aux_reg   <= `ACDP_AUX_RESET;
            state_reg <= acdp_pkg::ACDP_ST_RUN;
        end else begin
            aux_reg   <= aux_next;
            state_reg <= state_next;
        end
    end

    // Pointer requests go to the selected pointer
    always_comb begin
        bus.sel          = aux_reg[`ACDP_SEL_BIT];
        bus.op           = ptr_load ? acdp_pkg::ACDP_OP_LOAD :
                           (ptr_inc ? acdp_pkg::ACDP_OP_INC : acdp_pkg::ACDP_OP_NONE);
        bus.load_data    = ptr_load_data;
        bus.byte_wdata   = sfr_wdata;
        bus.byte_we_low  = low_wr;
        bus.byte_we_high = high_wr;
    end

    acdp_ptr_pair u_pair (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .bus      (bus)
    );

    // Read data for the three registers
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_re) begin
            rdata_next = read_mux(sfr_addr, aux_reg, bus.active);
        end
    end

    // Next values of the output stage
    always_comb begin
        ptr_out_next   = bus.active;
        code_next      = ptr_add(bus.active, ptr_offset);
        jump_next      = ptr_add(bus.active, ptr_offset);
        cfg_next       = bus.active;
        reset_out_next = (state_next == acdp_pkg::ACDP_ST_RESET);
        restart_next   = `ACDP_RESTART_ADDR;
    end

    // Read data holds until the next read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Pointer addresses, one cycle behind the pointer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr_out_reg <= 16'h0000;
            code_reg    <= 16'h0000;
            jump_reg    <= 16'h0000;
            cfg_reg     <= 16'h0000;
        end else begin
            ptr_out_reg <= ptr_out_next;
            code_reg    <= code_next;
            jump_reg    <= jump_next;
            cfg_reg     <= cfg_next;
        end
    end

    // Chip reset pulse and restart address
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reset_out_reg <= 1'b0;
            restart_reg   <= `ACDP_RESTART_ADDR;
        end else begin
            reset_out_reg <= reset_out_next;
            restart_reg   <= restart_next;
        end
    end

    // Register access result
    assign sfr_rdata        = rdata_reg;

    // Pointer users
    assign data_pointer     = ptr_out_reg;
    assign code_read_addr   = code_reg;
    assign jump_target      = jump_reg;
    assign config_read_addr = cfg_reg;

    // Full chip reset request
    assign chip_reset       = reset_out_reg;
    assign restart_addr     = restart_reg;
endmodule

// ---- hdl/acdp_pkg.sv ----
package acdp_pkg;

    // Pointer operations issued by the core
    typedef enum logic [2:0] {
        ACDP_OP_NONE,
        ACDP_OP_INC,
        ACDP_OP_LOAD
    } acdp_op_type;

    // Software reset sequencing states
    typedef enum logic [1:0] {
        ACDP_ST_RUN,
        ACDP_ST_RESET
    } acdp_state_type;

endpackage

// ---- hdl/acdp_ptr_if.sv ----
`timescale 1ns/100ps
// Bundle between control bank and pointer pair
interface acdp_ptr_if;
    logic                     sel;
    acdp_pkg::acdp_op_type    op;
    logic [15:0]              load_data;
    logic                     byte_we_low;
    logic                     byte_we_high;
    logic [7:0]               byte_wdata;
    logic [15:0]              active;

    modport ctrl (output sel, output op, output load_data, output byte_we_low,
                  output byte_we_high, output byte_wdata, input active);
    modport pair (input sel, input op, input load_data, input byte_we_low,
                  input byte_we_high, input byte_wdata, output active);
endinterface

// ---- hdl/acdp_ptr_pair.sv ----
`timescale 1ns/100ps
`include "acdp_regs.svh"
// Two independent 16-bit data pointers
module acdp_ptr_pair (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  soft_rst,
    // Control bundle
    acdp_ptr_if.pair   bus
);
    logic [15:0] ptr_reg [2];
    logic [15:0] ptr_next [2];

    // Only the selected pointer changes; soft reset clears both
    always_comb begin
        ptr_next[0] = ptr_reg[0];
        ptr_next[1] = ptr_reg[1];
        case (bus.op)
            acdp_pkg::ACDP_OP_INC: begin
                ptr_next[bus.sel] = ptr_reg[bus.sel] + 16'h0001;
            end
            acdp_pkg::ACDP_OP_LOAD: begin
                ptr_next[bus.sel] = bus.load_data;
            end
            default: begin
            end
        endcase
        if (bus.byte_we_low) begin
            ptr_next[bus.sel][7:0] = bus.byte_wdata;
        end
        if (bus.byte_we_high) begin
            ptr_next[bus.sel][15:8] = bus.byte_wdata;
        end
        if (soft_rst) begin
            ptr_next[0] = `ACDP_PTR_RESET;
            ptr_next[1] = `ACDP_PTR_RESET;
        end
    end

    // Pointer storage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr_reg[0] <= 16'h0000;
            ptr_reg[1] <= 16'h0000;
        end else begin
            ptr_reg[0] <= ptr_next[0];
            ptr_reg[1] <= ptr_next[1];
        end
    end

    // Unselected pointer stays hidden
    assign bus.active = ptr_reg[bus.sel];
endmodule

// ---- hdl/acdp_regs.svh ----
`ifndef ACDP_REGS_SVH
`define ACDP_REGS_SVH

// Special function register addresses
`define ACDP_AUX_CTRL_ADDR   8'ha2
`define ACDP_PTR_LOW_ADDR    8'h82
`define ACDP_PTR_HIGH_ADDR   8'h83

// Auxiliary control field positions
`define ACDP_SEL_BIT         0
`define ACDP_RSVD_BIT        1
`define ACDP_ZERO_BIT        2
`define ACDP_SOFT_RST_BIT    3

// Reset values
`define ACDP_AUX_RESET       8'h00
`define ACDP_PTR_RESET       16'h0000
`define ACDP_RESTART_ADDR    16'h0000

`endif

// ---- tb/acdp_aux_control_asserts.sv ----
`timescale 1ns/100ps
`include "acdp_regs.svh"
// Port checks of the control bank
module acdp_aux_control_asserts (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register access
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_we,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_re,
    input wire logic [7:0]  sfr_rdata,
    // Pointer side
    input wire logic        ptr_inc,
    input wire logic        ptr_load,
    input wire logic [15:0] ptr_load_data,
    input wire logic [7:0]  ptr_offset,
    input wire logic [15:0] data_pointer,
    input wire logic [15:0] code_read_addr,
    input wire logic [15:0] jump_target,
    input wire logic [15:0] config_read_addr,
    input wire logic        chip_reset,
    input wire logic [15:0] restart_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Reset request and restart
    AST_SOFT_RST_REQ: assert property (sfr_we && sfr_addr == `ACDP_AUX_CTRL_ADDR && sfr_wdata[3]
        && !chip_reset |=> chip_reset) else $error("no chip reset after write");
    AST_SOFT_RST_PULSE: assert property (chip_reset |=> !chip_reset)
        else $error("chip reset too long");
    AST_RESTART: assert property (restart_addr == `ACDP_RESTART_ADDR)
        else $error("restart address wrong");
    AST_CLEAR: assert property (chip_reset |-> ##[1:3] data_pointer == 16'h0000)
        else $error("pointer not cleared");
    // Pointer operations and the bit 2 read check
    AST_INC: assert property (ptr_inc && !ptr_load && !sfr_we ##1 !ptr_inc && !ptr_load
        && !sfr_we |=> data_pointer == $past(data_pointer) + 16'h0001) else $error("bad inc");
    AST_LOAD: assert property (ptr_load ##1 !ptr_load && !ptr_inc && !sfr_we
        |=> data_pointer == $past(ptr_load_data, 2)) else $error("bad load");
    AST_CODE: assert property (!$past(rst) |-> code_read_addr == data_pointer
        + {8'h00, $past(ptr_offset)}) else $error("bad code address");
    AST_JUMP: assert property (jump_target == code_read_addr)
        else $error("bad jump target");
    AST_CFG: assert property (config_read_addr == data_pointer)
        else $error("bad config address");
    AST_BIT2: assert property (sfr_re && sfr_addr == `ACDP_AUX_CTRL_ADDR
        |=> sfr_rdata[2] == 1'b0) else $error("bit 2 not zero");
    // Main scenarios
    cover property (chip_reset);
    cover property (ptr_inc);
    cover property (ptr_load);
endmodule
bind acdp_aux_control acdp_aux_control_asserts chk (.*);

// ---- tb/acdp_aux_control_bench.sv ----
`timescale 1ns/100ps
`include "acdp_regs.svh"
module acdp_aux_control_bench;
    logic        ref_clk, rst, sfr_we, sfr_re, ptr_inc, ptr_load, chip_reset, saw;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ptr_offset, q;
    logic [15:0] ptr_load_data, data_pointer, code_read_addr, jump_target, config_read_addr;
    logic [15:0] restart_addr;
    int          n_mismatch, n_compared;
    acdp_core_model core (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
        .sfr_wdata(sfr_wdata), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .ptr_inc(ptr_inc),
        .ptr_load(ptr_load), .ptr_load_data(ptr_load_data));
    acdp_aux_control dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
        .sfr_wdata(sfr_wdata), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .ptr_inc(ptr_inc),
        .ptr_load(ptr_load), .ptr_load_data(ptr_load_data), .ptr_offset(ptr_offset),
        .data_pointer(data_pointer), .code_read_addr(code_read_addr),
        .jump_target(jump_target), .config_read_addr(config_read_addr),
        .chip_reset(chip_reset), .restart_addr(restart_addr));
    // Clock
    always #5 ref_clk = ~ref_clk;
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        core.rd(a, q);
        chk("register read", {8'h00, e}, {8'h00, q});
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {ref_clk, rst, ptr_offset, saw, n_mismatch, n_compared} = {1'b0, 1'b1, 8'h10, 1'b0, 64'd0};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(`ACDP_AUX_CTRL_ADDR, 8'h00);
        core.pulse(1'b0, 1'b1, 16'h1234);
        core.wr(`ACDP_AUX_CTRL_ADDR, 8'h01);
        core.pulse(1'b0, 1'b1, 16'habcd);
        rdc(`ACDP_PTR_LOW_ADDR, 8'hcd);
        rdc(`ACDP_PTR_HIGH_ADDR, 8'hab);
        core.wr(`ACDP_AUX_CTRL_ADDR, 8'h00);
        rdc(`ACDP_PTR_HIGH_ADDR, 8'h12);
        core.wr(`ACDP_AUX_CTRL_ADDR, 8'hf4);
        rdc(`ACDP_AUX_CTRL_ADDR, 8'hf0);
        core.rd(`ACDP_AUX_CTRL_ADDR, q);
        core.wr(`ACDP_AUX_CTRL_ADDR, q + 8'h01);
        rdc(`ACDP_AUX_CTRL_ADDR, 8'hf1);
        settle();
        chk("selected pointer", 16'habcd, data_pointer);
        core.wr(`ACDP_AUX_CTRL_ADDR, 8'hf0);
        core.wr(`ACDP_PTR_LOW_ADDR, 8'h55);
        settle();
        chk("byte write", 16'h1255, data_pointer);
        core.pulse(1'b1, 1'b0, 16'h0000);
        settle();
        chk("increment", 16'h1256, data_pointer);
        chk("code address", 16'h1266, code_read_addr);
        chk("jump target", 16'h1266, jump_target);
        chk("config address", 16'h1256, config_read_addr);
        chk("restart address", 16'h0000, restart_addr);
        core.sw_reset();
        // Bounded wait for the reset pulse
        for (int i = 0; i < 4; i++) begin
            #1 saw = saw | (chip_reset === 1'b1);
            @(posedge ref_clk);
        end
        chk("chip reset", 16'h0001, {15'h0000, saw});
        if (!saw)
            tally_and_finish();
        settle();
        chk("cleared pointer", 16'h0000, data_pointer);
        rdc(`ACDP_AUX_CTRL_ADDR, 8'h00);
        core.wr(`ACDP_AUX_CTRL_ADDR, 8'h01);
        rdc(`ACDP_PTR_HIGH_ADDR, 8'h00);
        tally_and_finish();
    end
endmodule

// ---- tb/acdp_core_model.sv ----
`timescale 1ns/100ps
// Program side: register and pointer requests
module acdp_core_model (
    // Clock
    input wire logic        ref_clk,
    // Register access
    output logic [7:0]      sfr_addr,
    output logic            sfr_we,
    output logic [7:0]      sfr_wdata,
    output logic            sfr_re,
    input wire logic [7:0]  sfr_rdata,
    // Pointer requests
    output logic            ptr_inc,
    output logic            ptr_load,
    output logic [15:0]     ptr_load_data
);
    // Idle at time zero
    initial begin
        {sfr_addr, sfr_we, sfr_wdata, sfr_re, ptr_inc, ptr_load, ptr_load_data} = '0;
    end
    // One-cycle write strobe
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_we    <= 1'b1;
        @(posedge ref_clk);
        sfr_we    <= 1'b0;
    endtask
    // Normal write keeps bits 3 and 1 clear
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(a, (a == `ACDP_AUX_CTRL_ADDR) ? (d & 8'hf5) : d);
    endtask
    // Deliberate full reset
    task automatic sw_reset();
        put(`ACDP_AUX_CTRL_ADDR, 8'h08);
    endtask
    // Read, data one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_re   <= 1'b1;
        @(posedge ref_clk);
        sfr_re   <= 1'b0;
        #1 q = sfr_rdata;
    endtask
    // Pointer increment or load pulse
    task automatic pulse(input logic inc, input logic ld, input logic [15:0] d);
        @(posedge ref_clk);
        {ptr_inc, ptr_load, ptr_load_data} <= {inc, ld, d};
        @(posedge ref_clk);
        {ptr_inc, ptr_load} <= 2'b00;
    endtask
endmodule
